/* File: rtl/dwos_pkg.sv */
// constants, offsets and timing shared by both ends of the two-wire link
// assumes a 100 MHz system clock on both ends
//
// What this block does
// - start is sda falling while scl high
// - match fixed address or prefix plus pins
// - matching device pulls sda low, ninth pulse
// - r/w bit high reads, low writes
// - instruction msb selects channel one or two
// - shutdown bit isolates wiper, keeps stored code
// - codes accepted in shutdown, applied on exit
// - fuse bit blows fuses for current setting
// - fourth bit sent zero, last three ignored
// - overwrite unlocks; clearing restores fused setting
// - power-up preset midscale or fused, overwrite cleared
// - data byte msb first, acked ninth pulse
// - sda changes only while scl low
// - read sends wiper code of last channel
// - address plus instruction alone is valid
// - status byte follows: two fuse bits first
// - status 00 ready, 10 failed, 11 done
// - stop is sda rising while scl high
// - reader nacks last byte then stops
// - each further data byte reloads the wiper
// - new instruction needs a new transfer
// - reads repeat while master acknowledges
package dwos_pkg;
   // ************************************************************
   // serial addressing and instruction layout
   // ************************************************************
   localparam logic [6:0] ADDR_FIXED  = 7'h2f;
   localparam logic [4:0] ADDR_PREFIX = 5'h0b;
   localparam int         INS_CH      = 7;
   localparam int         INS_SHUT    = 6;
   localparam int         INS_FUSE    = 5;
   localparam int         INS_OVR     = 3;
   localparam logic [7:0] MIDSCALE    = 8'h80;
   localparam logic [3:0] BYTE_BITS   = 4'h8;
   // ************************************************************
   // timing
   // ************************************************************
   localparam int CLK_NS        = 10;
   localparam int SCL_PERIOD_NS = 160;
   localparam int QTR_CYC       = SCL_PERIOD_NS / (4 * CLK_NS);
   // ************************************************************
   // controller registers
   // ************************************************************
   localparam logic [3:0] REG_CMD  = 4'h0;
   localparam logic [3:0] REG_ADDR = 4'h1;
   localparam logic [3:0] REG_TX0  = 4'h2;
   localparam logic [3:0] REG_TX1  = 4'h3;
   localparam logic [3:0] REG_RX0  = 4'h4;
   localparam logic [3:0] REG_RX1  = 4'h5;
   localparam logic [3:0] REG_STAT = 4'h6;
   localparam int         CMD_GO   = 0;
   localparam int         CMD_RD   = 1;
   localparam int         CMD_NB   = 2;
   localparam int         ST_BUSY  = 0;
   localparam int         ST_NACK  = 1;
endpackage

/* File: rtl/dwos_if.sv */
// open-drain two-wire link between controller and potentiometer slave
// assumes pull-ups: a released line reads high
`timescale 1ns/1ps
interface dwos_if;
   logic scl_host_o;
   logic scl_host_oe;
   logic sda_host_o;
   logic sda_host_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic scl;
   logic sda;
   // sda is the wired-and of both drivers; scl has the controller driver alone
   assign scl = scl_host_oe ? scl_host_o : 1'b1;
   assign sda = (sda_host_oe ? sda_host_o : 1'b1) & (sda_dev_oe ? sda_dev_o : 1'b1);
   modport host (output scl_host_o, scl_host_oe, sda_host_o, sda_host_oe, input scl, sda);
   modport dev  (output sda_dev_o, sda_dev_oe, input scl, sda);
endinterface

/* File: rtl/dwos_sync.sv */
// two-flop synchroniser for pin levels
// assumes inputs are slow levels from outside the clock domain
`timescale 1ns/1ps
module dwos_sync #(
   parameter int W = 2
) (
   input  wire logic         sys_clk_in,
   input  wire logic         rst_in,
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] sync_out
);
   generate
      if (W < 1) begin : g_bad
         $error("width must be at least 1");
      end
   endgenerate
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } dwos_sync_t;
   dwos_sync_t r;
   dwos_sync_t n;
   // reset to idle-high so no false start is seen after release
   always_comb begin
      n    = r;
      n.s1 = pin_in;
      n.s2 = r.s1;
   end
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         r <= '{s1: '1, s2: '1};
      end else begin
         r <= n;
      end
   end
   assign sync_out = r.s2;
endmodule

/* File: rtl/dwos_dev.sv */
// slave end: two-wire engine, wiper latches, shutdown and fuse control
// assumes fuse array inputs are static levels on this clock; pins are async
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module dwos_dev #(
   parameter bit CFG_ADDR = 1'b0
) (
   input  wire logic             sys_clk_in,
   input  wire logic             rst_in,
   dwos_if.dev                   bus,
   input  wire logic             addr_pin_low_in,
   input  wire logic             addr_pin_high_in,
   input  wire logic             fuse_blown_in,
   input  wire logic             fuse_fail_in,
   input  wire logic [1:0][7:0]  fuse_code_in,
   output logic      [1:0][7:0]  wiper_latch_out,
   output logic      [1:0]       shutdown_bit_out,
   output logic                  fuse_prog_out,
   output logic      [1:0][7:0]  fuse_prog_code_out
);
   typedef enum logic [2:0] {
      D_INIT, D_IDLE, D_RX, D_RACK, D_TX, D_TACK
   } dwos_dst_t;

   typedef struct packed {
      dwos_dst_t      st;
      logic [7:0]     sh;
      logic [3:0]     cnt;
      logic [1:0]     bi;
      logic           rw;
      logic           ack;
      logic           ch;
      logic           sec;
      logic           scl_q;
      logic           sda_q;
      logic           sda_oe;
      logic [1:0][7:0] latch;
      logic [1:0][7:0] fused;
      logic [1:0]     shut;
      logic           ovr;
      logic           blown;
      logic           fail;
      logic           fuse_pend;
      logic           fuse_go;
   } dwos_dev_t;

   dwos_dev_t  r;
   dwos_dev_t  n;
   logic [3:0] pins;
   logic       scl_s;
   logic       sda_s;
   logic       addr_lo_s;
   logic       addr_hi_s;

   dwos_sync #(.W(4)) u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .pin_in     ({bus.scl, bus.sda, addr_pin_low_in, addr_pin_high_in}),
      .sync_out   (pins)
   );
   assign scl_s = pins[3];
   assign sda_s = pins[2];
   assign addr_lo_s = pins[1];
   assign addr_hi_s = pins[0];

   always_comb begin
      logic       rise;
      logic       fall;
      logic       start;
      logic       stop;
      logic [6:0] my_addr;
      logic [7:0] status;
      logic       load;
      logic [7:0] ldb;
      rise    = scl_s & ~r.scl_q;
      fall    = ~scl_s & r.scl_q;
      start   = scl_s & r.scl_q & r.sda_q & ~sda_s;
      stop    = scl_s & r.scl_q & ~r.sda_q & sda_s;
      my_addr = CFG_ADDR ? {dwos_pkg::ADDR_PREFIX, addr_hi_s, addr_lo_s} : dwos_pkg::ADDR_FIXED;
      status  = {r.blown, r.blown & ~r.fail, 6'h00};
      load    = 1'b0;
      ldb     = 8'h00;
      n         = r;
      n.scl_q   = scl_s;
      n.sda_q   = sda_s;
      n.fuse_go = 1'b0;
      if (r.fuse_go) begin
         n.fail = fuse_fail_in;
      end
      // ************************************************************
      // power-up preset, then byte engine
      // ************************************************************
      if (r.st == D_INIT) begin
         for (int i = 0; i < 2; i++) begin
            n.latch[i] = fuse_blown_in ? fuse_code_in[i] : dwos_pkg::MIDSCALE;
         end
         n.fused = fuse_code_in;
         n.blown = fuse_blown_in;
         n.ovr   = 1'b0;
         n.st    = D_IDLE;
      end else if (start) begin
         n.st     = D_RX;
         n.bi     = 2'd0;
         n.cnt    = 4'h0;
         n.sda_oe = 1'b0;
      end else if (stop) begin
         n.st     = D_IDLE;
         n.sda_oe = 1'b0;
         // fusing waits for stop so a data byte in the same frame is kept
         if (r.fuse_pend && !r.blown) begin
            n.fuse_go = 1'b1;
            n.blown   = 1'b1;
            n.fused   = r.latch;
         end
         n.fuse_pend = 1'b0;
      end else begin
         case (r.st)
            D_RX: begin
               if (rise) begin
                  n.sh  = {r.sh[6:0], sda_s};
                  n.cnt = r.cnt + 4'h1;
               end
               if (fall && r.cnt == dwos_pkg::BYTE_BITS) begin
                  n.cnt = 4'h0;
                  n.st  = D_RACK;
                  n.sda_oe = 1'b1;
                  case (r.bi)
                     2'd0: begin
                        n.rw = r.sh[0];
                        if (r.sh[7:1] != my_addr) begin
                           n.st     = D_IDLE;
                           n.sda_oe = 1'b0;
                        end
                     end
                     2'd1: begin
                        // unused instruction bits are not looked at
                        n.ch         = r.sh[dwos_pkg::INS_CH];
                        n.shut[n.ch] = r.sh[dwos_pkg::INS_SHUT];
                        n.fuse_pend  = r.sh[dwos_pkg::INS_FUSE];
                        n.ovr        = r.sh[dwos_pkg::INS_OVR];
                        if (r.ovr && !r.sh[dwos_pkg::INS_OVR] && r.blown) begin
                           n.latch = r.fused;
                        end
                     end
                     default: begin
                        if (!r.blown || r.ovr) begin
                           n.latch[r.ch] = r.sh;
                        end
                     end
                  endcase
               end
            end
            D_RACK: begin
               if (fall) begin
                  n.sda_oe = 1'b0;
                  if (r.rw && r.bi == 2'd0) begin
                     n.sec = 1'b0;
                     load  = 1'b1;
                     ldb   = r.latch[r.ch];
                  end else begin
                     n.st = D_RX;
                     n.bi = (r.bi == 2'd2) ? 2'd2 : r.bi + 2'd1;
                  end
               end
            end
            D_TX: begin
               if (fall) begin
                  if (r.cnt == 4'h7) begin
                     n.sda_oe = 1'b0;
                     n.st     = D_TACK;
                  end else begin
                     n.sh     = {r.sh[6:0], 1'b0};
                     n.sda_oe = ~r.sh[6];
                     n.cnt    = r.cnt + 4'h1;
                  end
               end
            end
            D_TACK: begin
               if (rise) begin
                  n.ack = ~sda_s;
               end
               if (fall) begin
                  if (r.ack) begin
                     n.sec = ~r.sec;
                     load  = 1'b1;
                     ldb   = r.sec ? r.latch[r.ch] : status;
                  end else begin
                     n.st = D_IDLE;
                  end
               end
            end
            default: begin
               n.sda_oe = 1'b0;
            end
         endcase
      end
      if (load) begin
         n.sh     = ldb;
         n.sda_oe = ~ldb[7];
         n.cnt    = 4'h0;
         n.st     = D_TX;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         r <= '{st: D_INIT, scl_q: 1'b1, sda_q: 1'b1, latch: {2{dwos_pkg::MIDSCALE}},
                default: '0};
      end else begin
         r <= n;
      end
   end

   // shutdown is reported per channel; the stored code stays on the latch
   assign bus.sda_dev_o        = 1'b0;
   assign bus.sda_dev_oe       = r.sda_oe;
   assign wiper_latch_out      = r.latch;
   assign shutdown_bit_out     = r.shut;
   assign fuse_prog_out        = r.fuse_go;
   assign fuse_prog_code_out   = r.fused;
endmodule

/* File: rtl/dwos_host.sv */
// controller end: register port in, framed two-wire transfers out
// assumes one master on the link; scl is made here by a divider
`timescale 1ns/1ps
module dwos_host #(
   parameter int QTR = dwos_pkg::QTR_CYC
) (
   input  wire logic       sys_clk_in,
   input  wire logic       rst_in,
   dwos_if.host            bus,
   input  wire logic [3:0] reg_addr_in,
   input  wire logic [7:0] reg_wdata_in,
   input  wire logic       reg_wr_in,
   input  wire logic       reg_rd_in,
   output logic      [7:0] reg_rdata_out
);
   generate
      if (QTR < 4 || QTR > 255) begin : g_bad
         $error("quarter period must be 4 to 255 cycles");
      end
   endgenerate

   typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} dwos_hst_t;

   typedef struct packed {
      dwos_hst_t       st;
      logic [7:0]      div;
      logic [1:0]      ph;
      logic [1:0]      bi;
      logic [3:0]      bitc;
      logic [7:0]      sh;
      logic            scl_oe;
      logic            sda_oe;
      logic            busy;
      logic            nack;
      logic            rd;
      logic [1:0]      nb;
      logic [6:0]      addr;
      logic [1:0][7:0] tx;
      logic [1:0][7:0] rx;
      logic [7:0]      rdata;
   } dwos_host_t;

   dwos_host_t r;
   dwos_host_t n;
   logic [1:0] pins;

   dwos_sync #(.W(2)) u_sync (
      .sys_clk_in (sys_clk_in),
      .rst_in     (rst_in),
      .pin_in     ({bus.scl, bus.sda}),
      .sync_out   (pins)
   );

   always_comb begin
      logic       tick;
      logic       txm;
      logic [1:0] last;
      tick = (r.div == 8'(QTR - 1));
      last = r.rd ? 2'd2 : r.nb;
      txm  = (r.bi == 2'd0) || !r.rd;
      n       = r;
      n.rdata = 8'h00;
      // ************************************************************
      // register port
      // ************************************************************
      if (reg_rd_in) begin
         if (reg_addr_in == dwos_pkg::REG_ADDR) begin
            n.rdata = {1'b0, r.addr};
         end else if (reg_addr_in == dwos_pkg::REG_TX0) begin
            n.rdata = r.tx[0];
         end else if (reg_addr_in == dwos_pkg::REG_TX1) begin
            n.rdata = r.tx[1];
         end else if (reg_addr_in == dwos_pkg::REG_RX0) begin
            n.rdata = r.rx[0];
         end else if (reg_addr_in == dwos_pkg::REG_RX1) begin
            n.rdata = r.rx[1];
         end else if (reg_addr_in == dwos_pkg::REG_STAT) begin
            n.rdata = {6'h00, r.nack, r.busy};
         end
      end
      if (reg_wr_in && !r.busy) begin
         if (reg_addr_in == dwos_pkg::REG_CMD && reg_wdata_in[dwos_pkg::CMD_GO]) begin
            n.rd   = reg_wdata_in[dwos_pkg::CMD_RD];
            n.nb   = reg_wdata_in[dwos_pkg::CMD_NB +: 2];
            n.busy = 1'b1;
            n.nack = 1'b0;
            n.st   = H_START;
            n.div  = 8'h00;
            n.ph   = 2'd0;
         end else if (reg_addr_in == dwos_pkg::REG_ADDR) begin
            n.addr = reg_wdata_in[6:0];
         end else if (reg_addr_in == dwos_pkg::REG_TX0) begin
            n.tx[0] = reg_wdata_in;
         end else if (reg_addr_in == dwos_pkg::REG_TX1) begin
            n.tx[1] = reg_wdata_in;
         end
      end
      // ************************************************************
      // bit sequencer, four quarter phases per scl period
      // ************************************************************
      if (r.st != H_IDLE) begin
         n.div = tick ? 8'h00 : r.div + 8'h01;
         if (tick) begin
            n.ph = r.ph + 2'd1;
            case (r.st)
               H_START: begin
                  if (r.ph == 2'd1) n.sda_oe = 1'b1;
                  if (r.ph == 2'd2) n.scl_oe = 1'b1;
                  if (r.ph == 2'd3) begin
                     n.st   = H_BIT;
                     n.bi   = 2'd0;
                     n.bitc = 4'h0;
                     n.sh   = {r.addr, r.rd};
                  end
               end
               H_BIT: begin
                  case (r.ph)
                     2'd0: begin
                        if (r.bitc != dwos_pkg::BYTE_BITS) begin
                           n.sda_oe = txm & ~r.sh[7];
                        end else begin
                           n.sda_oe = !txm && (r.bi != last);
                        end
                     end
                     2'd1: n.scl_oe = 1'b0;
                     2'd2: begin
                        if (r.bitc != dwos_pkg::BYTE_BITS) begin
                           n.sh = {r.sh[6:0], pins[0]};
                        end else if (txm) begin
                           n.nack = pins[0];
                        end else begin
                           n.rx[r.bi - 2'd1] = r.sh;
                        end
                     end
                     default: begin
                        n.scl_oe = 1'b1;
                        if (r.bitc == dwos_pkg::BYTE_BITS) begin
                           n.bitc = 4'h0;
                           // a nacked write is closed at once
                           if (r.nack || r.bi == last) begin
                              n.st = H_STOP;
                           end else begin
                              n.bi = r.bi + 2'd1;
                              n.sh = r.rd ? 8'h00 : r.tx[r.bi];
                           end
                        end else begin
                           n.bitc = r.bitc + 4'h1;
                        end
                     end
                  endcase
               end
               H_STOP: begin
                  if (r.ph == 2'd0) n.sda_oe = 1'b1;
                  if (r.ph == 2'd1) n.scl_oe = 1'b0;
                  if (r.ph == 2'd2) n.sda_oe = 1'b0;
                  if (r.ph == 2'd3) begin
                     n.st   = H_IDLE;
                     n.busy = 1'b0;
                  end
               end
               default: n.st = H_IDLE;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         r <= '{st: H_IDLE, default: '0};
      end else begin
         r <= n;
      end
   end

   assign bus.scl_host_o  = 1'b0;
   assign bus.sda_host_o  = 1'b0;
   assign bus.scl_host_oe = r.scl_oe;
   assign bus.sda_host_oe = r.sda_oe;
   assign reg_rdata_out   = r.rdata;
endmodule

/* File: tb/dwos_link_checker.sv */
// link checker: framing, acknowledge timing and sda discipline on the wire
// assumes the slave answers address 0x2f and scl high lasts over 4 cycles
`timescale 1ns/1ps
module dwos_link_checker (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic scl_host_oe,
   input wire logic sda_host_oe,
   input wire logic sda_dev_oe,
   input wire logic scl,
   input wire logic sda
);
   // ************
   // frame tracking
   // ************
   logic       scl_q;
   logic       sda_q;
   logic       in_frame;
   logic [3:0] cnt;
   logic [1:0] byte_idx;
   logic [7:0] addr_sh;
   wire logic  rise = scl & ~scl_q;
   wire logic  fall = ~scl & scl_q;
   wire logic  rd   = addr_sh[0] & (byte_idx != 2'h0);
   wire logic  hit  = addr_sh[7:1] == dwos_pkg::ADDR_FIXED;
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   always_ff @(posedge sys_clk_in) begin
      scl_q <= scl;
      sda_q <= sda;
      if (rst_in) begin
         in_frame <= 1'b0;
         cnt      <= 4'h0;
         byte_idx <= 2'h0;
         addr_sh  <= 8'h00;
      end else if (scl && scl_q && sda_q && !sda) begin
         in_frame <= 1'b1;
         cnt      <= 4'h0;
         byte_idx <= 2'h0;
      end else if (scl && scl_q && !sda_q && sda) begin
         in_frame <= 1'b0;
      end else if (rise && in_frame) begin
         cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
         // saturate: only the first bytes matter for direction
         if (cnt == 4'h8 && byte_idx != 2'h3) begin
            byte_idx <= byte_idx + 2'h1;
         end
         if (byte_idx == 2'h0 && cnt != 4'h8) begin
            addr_sh <= {addr_sh[6:0], sda};
         end
      end
   end
   sequence s_start;
      scl && scl_q && sda_q && !sda;
   endsequence
   sequence s_stop;
      scl && scl_q && !sda_q && sda;
   endsequence
   sequence s_ninth;
      in_frame && rise && cnt == 4'h8;
   endsequence
   // ************
   // properties
   // ************
   a_start_scl_low: assert property (s_start |-> ##[1:6] !scl)
      else $error("scl not lowered after start");
   a_stop_scl_idle: assert property (s_stop |-> !scl_host_oe [*4])
      else $error("scl pulled right after stop");
   a_idle_no_drive: assert property (!in_frame |-> !sda_dev_oe)
      else $error("slave drives sda outside a frame");
   a_dev_sda_steady: assert property (scl && scl_q |-> $stable(sda_dev_oe))
      else $error("slave sda changed while scl high");
   a_addr_ack_match: assert property (s_ninth ##0 (byte_idx == 2'h0) |-> sda_dev_oe == hit)
      else $error("address acknowledge wrong");
   a_ack_only_ninth: assert property (in_frame && !rd && $rose(sda_dev_oe) |-> cnt == 4'h8)
      else $error("slave pulled sda outside ninth pulse");
   a_data_ack_write: assert property (s_ninth ##0 (byte_idx != 2'h0 && !rd && hit) |-> sda_dev_oe)
      else $error("write byte not acknowledged");
   a_read_ack_free: assert property (s_ninth ##0 rd |-> !sda_dev_oe)
      else $error("slave holds sda on master acknowledge");
   a_ack_release_bound: assert property (in_frame && fall && cnt == 4'h0 && byte_idx != 2'h0 && !rd
                                         |-> ##[1:4] !sda_dev_oe)
      else $error("acknowledge not released");
   a_read_host_ack: assert property (s_ninth ##0 rd
                                     |-> sda_host_oe == (byte_idx == 2'h1))
      else $error("controller acknowledge wrong in read");
endmodule

/* File: tb/dwos_tb.sv */
// bench: controller and slave joined by the link, register port driven here
// assumes 100 MHz clock; the controller reads two bytes per read frame
`timescale 1ns/1ps
module dwos_tb;
   typedef struct packed {
      logic [7:0] ins;
      logic [7:0] d;
      logic [7:0] cmd;
      logic [1:0] shut;
      logic [7:0] w0;
      logic [7:0] w1;
   } dwos_row_t;
   logic            sys_clk_in;
   logic            rst_in;
   logic [3:0]      reg_addr;
   logic [7:0]      reg_wdata;
   logic            reg_wr;
   logic            reg_rd;
   logic [7:0]      reg_rdata;
   logic            pin_lo;
   logic            pin_hi;
   logic            fuse_blown;
   logic            fuse_fail;
   logic [1:0][7:0] fuse_code;
   logic [1:0][7:0] wiper;
   logic [1:0]      shut;
   logic            prog;
   logic [1:0][7:0] prog_code;
   logic [7:0]      rx;
   int              error_cnt = 0;
   int              checks_done = 0;
   int              prog_cnt = 0;
   dwos_row_t       rows [6] = '{'{8'h00, 8'h00, 8'h09, 2'h0, 8'h00, 8'h80},
                                 '{8'h80, 8'hff, 8'h09, 2'h0, 8'h00, 8'hff},
                                 '{8'h07, 8'h5a, 8'h09, 2'h0, 8'h5a, 8'hff},
                                 '{8'hc0, 8'h33, 8'h09, 2'h2, 8'h5a, 8'h33},
                                 '{8'h80, 8'h44, 8'h09, 2'h0, 8'h5a, 8'h44},
                                 '{8'h00, 8'h00, 8'h05, 2'h0, 8'h5a, 8'h44}};
   dwos_if i_dwos_if ();
   dwos_host #(.QTR(4)) i_dwos_host (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .bus(i_dwos_if.host), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
      .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata));
   dwos_dev #(.CFG_ADDR(1'b1)) i_dwos_dev (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .bus(i_dwos_if.dev), .addr_pin_low_in(pin_lo), .addr_pin_high_in(pin_hi),
      .fuse_blown_in(fuse_blown), .fuse_fail_in(fuse_fail), .fuse_code_in(fuse_code),
      .wiper_latch_out(wiper), .shutdown_bit_out(shut), .fuse_prog_out(prog),
      .fuse_prog_code_out(prog_code));
   dwos_link_checker i_dwos_link_checker (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .scl_host_oe(i_dwos_if.scl_host_oe), .sda_host_oe(i_dwos_if.sda_host_oe),
      .sda_dev_oe(i_dwos_if.sda_dev_oe), .scl(i_dwos_if.scl), .sda(i_dwos_if.sda));
   // ************
   // tasks
   // ************
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
         error_cnt++;
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk_in);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd <= 1'b0;
      #1;
      rx = reg_rdata;
   endtask
   task automatic xfer(input logic [7:0] ad, input logic [7:0] ins, input logic [7:0] d,
                       input logic [7:0] cmd);
      int n;
      wr(dwos_pkg::REG_ADDR, ad);
      wr(dwos_pkg::REG_TX0, ins);
      wr(dwos_pkg::REG_TX1, d);
      wr(dwos_pkg::REG_CMD, cmd);
      for (n = 0; n < 1000; n++) begin
         rd(dwos_pkg::REG_STAT);
         if (rx[dwos_pkg::ST_BUSY] === 1'b0) break;
      end
      if (n == 1000) chk("busy", 8'h0, 8'h1);
      // slave sees the stop one clock before the controller clears busy
      repeat (8) @(posedge sys_clk_in);
   endtask
   task automatic rdback(input logic [7:0] code, input logic [1:0] st);
      xfer(8'h2f, 8'h00, 8'h00, 8'h03);
      rd(dwos_pkg::REG_RX0);
      chk("read code", code, rx);
      rd(dwos_pkg::REG_RX1);
      chk("status", {st, 6'h0}, {rx[7:6], 6'h0});
   endtask
   task automatic do_reset();
      @(posedge sys_clk_in);
      rst_in <= 1'b1;
      repeat (1) @(posedge sys_clk_in);
      #1;
      chk("wiper in reset", 8'h80, wiper[0]);
      @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (3) @(posedge sys_clk_in);
   endtask
   task automatic tally_and_finish();
      if (error_cnt == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ************
   // stimulus
   // ************
   always @(posedge sys_clk_in) begin
      if (prog === 1'b1) prog_cnt <= prog_cnt + 1;
   end
   initial begin
      sys_clk_in = 1'b0;
      forever #5 sys_clk_in = ~sys_clk_in;
   end
   initial begin
      #900000;
      error_cnt++;
      tally_and_finish();
   end
   initial begin
      rst_in     = 1'b1;
      reg_addr   = 4'h0;
      reg_wdata  = 8'h00;
      reg_wr     = 1'b0;
      reg_rd     = 1'b0;
      pin_lo     = 1'b1;
      pin_hi     = 1'b1;
      fuse_blown = 1'b0;
      fuse_fail  = 1'b0;
      fuse_code  = '0;
      do_reset();
      chk("preset ch2", 8'h80, wiper[1]);
      rdback(8'h80, 2'h0);
      rd(4'hf);
      chk("unmapped", 8'h00, rx);
      foreach (rows[i]) begin
         xfer(8'h2f, rows[i].ins, rows[i].d, rows[i].cmd);
         chk("wiper ch1", rows[i].w0, wiper[0]);
         chk("wiper ch2", rows[i].w1, wiper[1]);
         chk("shutdown", {6'h0, rows[i].shut}, {6'h0, shut});
         rdback(rows[i].ins[7] ? rows[i].w1 : rows[i].w0, 2'h0);
      end
      xfer(8'h2e, 8'h00, 8'h11, 8'h09);
      rd(dwos_pkg::REG_STAT);
      chk("nack", 8'h01, {7'h0, rx[dwos_pkg::ST_NACK]});
      chk("foreign write", 8'h5a, wiper[0]);
      xfer(8'h2f, 8'h20, 8'h77, 8'h09);
      chk("prog pulses", 8'h01, prog_cnt[7:0]);
      chk("prog code", 8'h77, prog_code[0]);
      rdback(8'h77, 2'h3);
      fuse_fail <= 1'b1;
      do_reset();
      rdback(8'h80, 2'h0);
      xfer(8'h2f, 8'h20, 8'h66, 8'h09);
      rdback(8'h66, 2'h2);
      fuse_blown <= 1'b1;
      fuse_fail  <= 1'b0;
      fuse_code  <= {8'h3c, 8'hc3};
      do_reset();
      chk("fused ch1", 8'hc3, wiper[0]);
      chk("fused ch2", 8'h3c, wiper[1]);
      xfer(8'h2f, 8'h20, 8'h11, 8'h09);
      chk("locked ch1", 8'hc3, wiper[0]);
      chk("no reblow", 8'h02, prog_cnt[7:0]);
      xfer(8'h2f, 8'h08, 8'h11, 8'h09);
      chk("overwrite ch1", 8'h11, wiper[0]);
      xfer(8'h2f, 8'h00, 8'h00, 8'h05);
      chk("restored ch1", 8'hc3, wiper[0]);
      rdback(8'hc3, 2'h3);
      tally_and_finish();
   end
endmodule
